// *** hw/mtr_resolver.v ***
// Purpose: resolve the effective memory type of each access
// Assumes: range matching is done upstream; page bits from the walker
// Notes: lookup path is combinational, register port answers in 1 cycle
`timescale 1ns/100ps
`include "mtr_map.vh"

module mtr_resolver #(
    parameter VAR_PAIRS = 8,
    parameter FIX_SUPPORT = 1,
    parameter WC_SUPPORT = 1
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // model register port
    input wire regReq,
    input wire regWr,
    input wire [11:0] regAddr,
    input wire [63:0] regWdata,
    output reg regAck_q,
    output reg [63:0] regRdata_q,
    output reg regFault_q,
    // feature query
    input wire featQuery,
    output reg [31:0] featWord_q,
    // global cache controls
    input wire globalCacheDisable,
    input wire globalNoWriteback,
    // range lookup from the address matchers
    input wire inLowMeg,
    input wire fixedHit,
    input wire [7:0] fixedType,
    input wire [VAR_PAIRS-1:0] varHit,
    input wire [8*VAR_PAIRS-1:0] varTypes,
    // page-table entry bits
    input wire attrIndexBit,
    input wire pageCacheDisable,
    input wire pageWritethrough,
    // resolved type and behaviour
    output reg [7:0] effType,
    output reg [7:0] rangeType,
    output reg typeUndef,
    output wire cacheable,
    output wire readAllocShared,
    output wire writeAlloc,
    output wire writeToMem,
    output wire writeHitInval,
    output wire combineOk,
    output wire specReadOk
);

    // lookup path: range type from fixed, variable or default ranges,
    // then merged with the page slot; nothing on it is clocked, so
    // the walker sees the answer in the cycle it asks
    // limitation: effType and its flags are not flopped; the caller
    // must fit the whole decode inside its own pipeline stage
    // register path: one request per cycle, answered the next cycle,
    // faulted or not, so software never waits on a missing answer
    // typeUndef marks a mix software must avoid; the type shown then
    // is uncacheable, the safest pick for an undefined case
    // the table resets to the legacy page-bit types, so a walker that
    // never sets the index bit sees the old cache-disable behaviour

    // model register state
    reg [63:0] attrTable_q;
    reg [63:0] defType_q;

    // capability word is fixed by build parameters
    wire [63:0] capWord;
    wire [7:0] pairCount;
    wire fixBit;
    wire wcBit;
    wire featRange;

    // write checking
    reg attrBad;
    reg defBad;
    integer k;
    reg [7:0] slot;

    // range and page resolution
    wire varAny;
    wire [7:0] varMerged;
    wire varUndef;
    wire rangeOn;
    wire fixedOn;
    wire [2:0] slotIdx;
    reg [7:0] pageType;

    // encoding accepted in a slot or the default type field
    // combining is refused when not built in, so no slot can hold
    // a type the cache pipe has no decode for
    function typeOk;
        input [7:0] code;
        input allowMinus;
        begin
            case (code)
                `MTR_TYPE_UC: typeOk = 1'b1;
                `MTR_TYPE_WT: typeOk = 1'b1;
                `MTR_TYPE_WP: typeOk = 1'b1;
                `MTR_TYPE_WB: typeOk = 1'b1;
                `MTR_TYPE_WC: typeOk = (WC_SUPPORT != 0);
                `MTR_TYPE_UCM: typeOk = allowMinus;
                default: typeOk = 1'b0;
            endcase
        end
    endfunction

    // capability fields
    // build constants only: nothing software writes reaches them
    assign pairCount = VAR_PAIRS[7:0]; // RULE_03
    assign fixBit = (FIX_SUPPORT != 0); // RULE_04
    assign wcBit = (WC_SUPPORT != 0); // RULE_05
    // bit 9 is reserved and reads zero
    assign capWord = {53'h0, wcBit, 1'b0, fixBit, pairCount};
    // feature visible whenever any range typing is built in
    assign featRange = (VAR_PAIRS != 0) || (FIX_SUPPORT != 0);

    // reserved bits and encodings of a pending write
    // one bad byte refuses the whole word, never a partial update
    always @* begin
        attrBad = 1'b0;
        slot = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            slot = regWdata[8*k +: 8];
            if ((slot & `MTR_SLOT_RSVD) != 8'h00) begin
                attrBad = 1'b1; // RULE_18
            end else if (!typeOk(slot, 1'b1)) begin
                attrBad = 1'b1; // RULE_19
            end
        end
        // minus type only lives in the attribute table
        defBad = ((regWdata & `MTR_DEF_RSVD) != 64'h0) ||
                 !typeOk(regWdata[7:0], 1'b0);
    end

    // model register port: one request, one ack next cycle
    // read data is zero outside the answer cycle, so a stray
    // sample on an idle cycle never shows stale table contents
    always @(posedge clk) begin
        if (rst) begin
            regAck_q <= 1'b0;
            regRdata_q <= 64'h0;
            regFault_q <= 1'b0;
            attrTable_q <= `MTR_ATTR_RESET; // RULE_23
            defType_q <= `MTR_DEF_RESET;
        end else begin
            regAck_q <= regReq;
            regFault_q <= 1'b0;
            regRdata_q <= 64'h0;
            if (regReq) begin
                if (regAddr == `MTR_ADDR_CAP) begin
                    if (regWr) begin
                        regFault_q <= 1'b1; // RULE_02
                    end else begin
                        regRdata_q <= capWord;
                    end
                end else if (regAddr == `MTR_ADDR_ATTR) begin
                    if (!regWr) begin
                        regRdata_q <= attrTable_q; // RULE_16
                    end else if (attrBad) begin
                        // faulted writes leave every slot untouched
                        regFault_q <= 1'b1; // RULE_18
                    end else begin
                        attrTable_q <= regWdata; // RULE_16
                    end
                end else if (regAddr == `MTR_ADDR_DEF) begin
                    if (!regWr) begin
                        regRdata_q <= defType_q;
                    end else if (defBad) begin
                        regFault_q <= 1'b1;
                    end else begin
                        defType_q <= regWdata;
                    end
                end else begin
                    // no such register: fault on read or write
                    regFault_q <= 1'b1;
                end
            end
        end
    end

    // feature word captured on each query
    // the word holds between queries so a late reader still sees it
    always @(posedge clk) begin
        if (rst) begin
            featWord_q <= 32'h0;
        end else if (featQuery) begin
            featWord_q <= 32'h0;
            featWord_q[`MTR_FEAT_RANGE_BIT] <= featRange; // RULE_01
        end
    end

    // variable-range overlap merge
    // undefined mixes come back uncacheable with a flag raised
    mtr_range_merge #(
        .N(VAR_PAIRS)
    ) uMerge (
        .hit(varHit),
        .types(varTypes),
        .anyHit(varAny),
        .mergedType(varMerged),
        .undef(varUndef)
    );

    // enables from the default-type register
    // fixed ranges need both enables and the build option
    // clearing the master enable drops every range to uncacheable
    assign rangeOn = defType_q[`MTR_DEF_E_BIT];
    assign fixedOn = rangeOn && defType_q[`MTR_DEF_FE_BIT] &&
                     (FIX_SUPPORT != 0);

    // range type: fixed, then variable, then default
    // the default field is used as written; a minus code there is
    // refused on write, so it never reaches the combine stage
    always @* begin
        typeUndef = 1'b0;
        if (!rangeOn) begin
            rangeType = `MTR_TYPE_UC; // RULE_25
        end else if (fixedOn && inLowMeg && fixedHit) begin
            rangeType = fixedType; // RULE_11
        end else if (varAny) begin
            rangeType = varMerged;
            // conflicting ranges in one page are flagged, not resolved
            typeUndef = varUndef; // RULE_10
        end else begin
            rangeType = defType_q[7:0];
        end
    end

    // attribute slot picked by the three page bits
    assign slotIdx = {attrIndexBit, pageCacheDisable,
                      pageWritethrough}; // RULE_24

    // slot contents, read without a clock edge
    // plain indexed read: slot i sits in bits 8i+7:8i
    always @* begin
        pageType = attrTable_q[8*slotIdx +: 8];
    end

    // combine page slot with range type; no register in the path
    // global controls win over every slot: with caching off no line
    // may be allocated, whatever the page or the ranges say
    always @* begin
        effType = `MTR_TYPE_UC; // RULE_26
        if (globalCacheDisable || globalNoWriteback) begin
            // caching off: nothing may be cached
            effType = `MTR_TYPE_UC;
        end else begin
            case (pageType)
                `MTR_TYPE_WB: begin
                    effType = rangeType; // RULE_06
                end
                `MTR_TYPE_WT: begin
                    if (rangeType == `MTR_TYPE_WB) begin
                        effType = `MTR_TYPE_WT; // RULE_08
                    end else begin
                        effType = rangeType; // RULE_08
                    end
                end
                `MTR_TYPE_UCM: begin
                    // combining range wins over the minus type
                    if (rangeType == `MTR_TYPE_WC) begin
                        effType = `MTR_TYPE_WC; // RULE_09
                    end else begin
                        effType = `MTR_TYPE_UC; // RULE_17
                    end
                end
                `MTR_TYPE_UC: begin
                    effType = `MTR_TYPE_UC; // RULE_07
                end
                `MTR_TYPE_WC: begin
                    // combining page ignores the range type
                    effType = `MTR_TYPE_WC;
                end
                `MTR_TYPE_WP: begin
                    // uncacheable ranges stay uncacheable here
                    if (rangeType == `MTR_TYPE_UC) begin
                        effType = `MTR_TYPE_UC;
                    end else begin
                        effType = `MTR_TYPE_WP;
                    end
                end
                default: begin
                    // codes the write check refuses; kept safe anyway
                    effType = `MTR_TYPE_UC;
                end
            endcase
        end
    end

    // behaviour flags of the resolved type
    // flags follow effType in the same cycle, like the type itself
    mtr_type_attr uAttr (
        .typeCode(effType),
        .cacheable(cacheable),
        .readAllocShared(readAllocShared),
        .writeAlloc(writeAlloc),
        .writeToMem(writeToMem),
        .writeHitInval(writeHitInval),
        .combineOk(combineOk),
        .specReadOk(specReadOk)
    );

endmodule // mtr_resolver

// *** hw/mtr_map.vh ***
// Purpose: constants for the memory type resolver
// Assumes: included by the resolver files by bare name
// Notes: register numbers on the model register port are local picks
//
// Function
// RULE_01: feature query bit 12 flags range typing
// RULE_02: capability register read-only, write faults
// RULE_03: capability bits 7:0 give pair count
// RULE_04: capability bit 8: all fixed or none
// RULE_05: capability bit 10 set only with combining
// RULE_06: clear page bits take range type
// RULE_07: page cache-disable forces uncacheable
// RULE_08: page writethrough turns writeback into writethrough
// RULE_09: cache-disable, combining range: chosen result combining
// RULE_10: conflicting ranges in large page undefined
// RULE_11: fixed ranges win inside first megabyte
// RULE_12: identical overlapping variable types used as-is
// RULE_13: any uncacheable overlap gives uncacheable
// RULE_14: writethrough plus writeback overlap gives writethrough
// RULE_15: software avoids other overlap combinations
// RULE_16: attribute table is 64 bits, eight slots
// RULE_17: uncacheable-minus slot yields to combining range
// RULE_18: reserved attribute bits nonzero on write fault
// RULE_19: unsupported slot encoding on write faults
// RULE_20: type encodings 00,01,04,05,06
// RULE_21: writethrough: shared read allocate, no write allocate
// RULE_22: write-protect: writes to memory, hits invalidate
// RULE_23: slot reset pattern writeback, writethrough, minus, uncacheable
// RULE_24: slot chosen by index, disable, writethrough bits
// RULE_25: range enable clear forces uncacheable default
// RULE_26: effective type valid in same cycle
`ifndef MTR_MAP_VH
`define MTR_MAP_VH

// memory type encodings
`define MTR_TYPE_UC 8'h00
`define MTR_TYPE_WC 8'h01
`define MTR_TYPE_WT 8'h04
`define MTR_TYPE_WP 8'h05
`define MTR_TYPE_WB 8'h06
`define MTR_TYPE_UCM 8'h07

// register numbers on the model register port
`define MTR_ADDR_CAP 12'h010
`define MTR_ADDR_ATTR 12'h020
`define MTR_ADDR_DEF 12'h030

// capability register fields
`define MTR_CAP_FIX_BIT 8
`define MTR_CAP_WC_BIT 10

// feature word field
`define MTR_FEAT_RANGE_BIT 12

// default-type register fields and reserved mask
`define MTR_DEF_FE_BIT 10
`define MTR_DEF_E_BIT 11
`define MTR_DEF_RSVD 64'hffff_ffff_ffff_f300
`define MTR_DEF_RESET 64'h0000_0000_0000_0000

// attribute table layout and reset value
`define MTR_SLOT_W 8
`define MTR_SLOT_RSVD 8'hf8
`define MTR_ATTR_RESET 64'h0007_0406_0007_0406

`endif

// *** hw/mtr_range_merge.v ***
// Purpose: merge types of overlapping variable ranges
// Assumes: one type byte per range, hit vector marks matches
// Notes: undefined combinations report uncacheable plus a flag
`timescale 1ns/100ps
`include "mtr_map.vh"

module mtr_range_merge #(
    parameter N = 8
) (
    // per-range hits and types
    input wire [N-1:0] hit,
    input wire [8*N-1:0] types,
    // merged result
    output reg anyHit,
    output reg [7:0] mergedType,
    output reg undef
);

    integer i;
    reg allSame;
    reg anyUc;
    reg onlyWtWb;
    reg anyWt;
    reg [7:0] firstType;
    reg [7:0] t;

    // scan every hit range for overlap classes
    always @* begin
        anyHit = 1'b0;
        allSame = 1'b1;
        anyUc = 1'b0;
        onlyWtWb = 1'b1;
        anyWt = 1'b0;
        firstType = `MTR_TYPE_UC;
        t = `MTR_TYPE_UC;
        for (i = 0; i < N; i = i + 1) begin
            t = types[8*i +: 8];
            if (hit[i]) begin
                if (!anyHit) begin
                    firstType = t;
                end else if (t != firstType) begin
                    allSame = 1'b0;
                end
                anyHit = 1'b1;
                if (t == `MTR_TYPE_UC) anyUc = 1'b1;
                if (t == `MTR_TYPE_WT) anyWt = 1'b1;
                if (t != `MTR_TYPE_WT && t != `MTR_TYPE_WB) onlyWtWb = 1'b0;
            end
        end
        undef = 1'b0;
        if (!anyHit) begin
            mergedType = `MTR_TYPE_UC;
        end else if (anyUc) begin
            mergedType = `MTR_TYPE_UC; // RULE_13
        end else if (allSame) begin
            mergedType = firstType; // RULE_12
        end else if (onlyWtWb && anyWt) begin
            mergedType = `MTR_TYPE_WT; // RULE_14
        end else begin
            // safest answer for a combination software must avoid
            mergedType = `MTR_TYPE_UC; // RULE_15
            undef = 1'b1;
        end
    end

endmodule // mtr_range_merge

// *** hw/mtr_type_attr.v ***
// Purpose: cache behaviour implied by one memory type
// Assumes: type is one of the supported encodings
// Notes: unsupported encodings behave as uncacheable
`timescale 1ns/100ps
`include "mtr_map.vh"

module mtr_type_attr (
    // effective type
    input wire [7:0] typeCode,
    // behaviour flags for the cache pipeline
    output reg cacheable,
    output reg readAllocShared,
    output reg writeAlloc,
    output reg writeToMem,
    output reg writeHitInval,
    output reg combineOk,
    output reg specReadOk
);

    // one case per encoding, except uncacheable and minus, which take the default
    always @* begin
        cacheable = 1'b0;
        readAllocShared = 1'b0;
        writeAlloc = 1'b0;
        writeToMem = 1'b1;
        writeHitInval = 1'b0;
        combineOk = 1'b0;
        specReadOk = 1'b0;
        case (typeCode)
            `MTR_TYPE_WC: begin
                combineOk = 1'b1; // RULE_20
                specReadOk = 1'b1;
            end
            `MTR_TYPE_WT: begin
                cacheable = 1'b1;
                readAllocShared = 1'b1; // RULE_21
            end
            `MTR_TYPE_WP: begin
                cacheable = 1'b1;
                readAllocShared = 1'b1;
                writeHitInval = 1'b1; // RULE_22
            end
            `MTR_TYPE_WB: begin
                cacheable = 1'b1;
                writeAlloc = 1'b1;
                writeToMem = 1'b0;
                specReadOk = 1'b1;
            end
            default: begin
                writeToMem = 1'b1;
            end
        endcase
    end

endmodule // mtr_type_attr

// *** verif/mtr_resolver_sva.sv ***
// Purpose: port assertions for the resolver
// Assumes: one clock; lookup checks need the reset table
// Notes: table tracking ignores writes that fault
`timescale 1ns/100ps
module mtr_resolver_chk #(
    parameter VAR_PAIRS = 8,
    parameter FIX_SUPPORT = 1,
    parameter WC_SUPPORT = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port and feature word
    input wire logic regReq,
    input wire logic regWr,
    input wire logic [11:0] regAddr,
    input wire logic [63:0] regWdata,
    input wire logic regAck_q,
    input wire logic regFault_q,
    input wire logic [63:0] regRdata_q,
    input wire logic featQuery,
    input wire logic [31:0] featWord_q,
    // lookup
    input wire logic globalCacheDisable,
    input wire logic globalNoWriteback,
    input wire logic pageCacheDisable,
    input wire logic pageWritethrough,
    input wire logic [7:0] rangeType,
    input wire logic [7:0] effType
);
    localparam logic [63:0] RST_T = 64'h0007_0406_0007_0406;
    localparam logic [10:0] CAP = {WC_SUPPORT != 0, 1'b0, FIX_SUPPORT != 0,
        8'(VAR_PAIRS)};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic dflt_q;
    wire logic on = !globalCacheDisable && !globalNoWriteback;
    // a write lands only when every slot holds a supported code
    function automatic logic lands(input logic [63:0] d);
        lands = 1'b1;
        for (int i = 0; i < 8; i++) begin
            case (d[8*i +: 8])
                8'h00, 8'h04, 8'h05, 8'h06, 8'h07: ;
                8'h01: if (WC_SUPPORT == 0) lands = 1'b0;
                default: lands = 1'b0;
            endcase
        end
    endfunction
    // a faulting write leaves the table alone, so only clean data counts
    always @(posedge clk) begin
        if (rst)
            dflt_q <= 1'b1;
        else if (regReq && regWr && regAddr == 12'h020 && lands(regWdata))
            dflt_q <= regWdata == RST_T;
    end
    // access shapes
    sequence capWr;
        regReq && regWr && regAddr == 12'h010;
    endsequence
    sequence capRd;
        regReq && !regWr && regAddr == 12'h010;
    endsequence
    sequence attrBad;
        regReq && regWr && regAddr == 12'h020 &&
            (regWdata & 64'hf8f8_f8f8_f8f8_f8f8) != 64'h0;
    endsequence
    cap_write_fault_a: assert property (
        capWr |=> regAck_q && regFault_q)
        else $error("capability write not faulted");
    cap_read_value_a: assert property (
        capRd |=> regRdata_q == {53'h0, CAP})
        else $error("capability value wrong");
    attr_rsvd_a: assert property (
        attrBad |=> regAck_q && regFault_q)
        else $error("reserved attribute bits not faulted");
    attr_reset_a: assert property (
        regReq && !regWr && regAddr == 12'h020 && dflt_q
        |=> regRdata_q == RST_T)
        else $error("attribute table not at reset value");
    feat_hold_a: assert property (
        !featQuery |=> $stable(featWord_q))
        else $error("feature word changed without query");
    clear_page_a: assert property (
        on && dflt_q && !pageCacheDisable && !pageWritethrough
        |-> effType == rangeType)
        else $error("clear page bits did not take range type");
    wt_page_a: assert property (
        on && dflt_q && !pageCacheDisable && pageWritethrough
        |-> effType == ((rangeType == 8'h06) ? 8'h04 : rangeType))
        else $error("writethrough page type wrong");
    pcd_page_a: assert property (
        on && dflt_q && pageCacheDisable |-> effType ==
        ((!pageWritethrough && rangeType == 8'h01) ? 8'h01 : 8'h00))
        else $error("cache-disabled page type wrong");
endmodule // mtr_resolver_chk

bind mtr_resolver mtr_resolver_chk #(.VAR_PAIRS(VAR_PAIRS),
    .FIX_SUPPORT(FIX_SUPPORT), .WC_SUPPORT(WC_SUPPORT)) u_chk (.clk, .rst,
    .regReq, .regWr, .regAddr, .regWdata, .regAck_q, .regFault_q,
    .regRdata_q, .featQuery, .featWord_q, .globalCacheDisable,
    .globalNoWriteback, .pageCacheDisable, .pageWritethrough, .rangeType,
    .effType);

// *** verif/mtr_core_pipe.sv ***
// Purpose: paging and cache pipeline side of the resolver
// Assumes: range matching done; two variable ranges used
// Notes: unused range slots carry an unsupported code to catch stray use
`timescale 1ns/100ps
module mtr_core_pipe #(
    parameter VAR_PAIRS = 8
) (
    // range lookup
    output logic inLowMeg,
    output logic fixedHit,
    output logic [7:0] fixedType,
    output logic [VAR_PAIRS-1:0] varHit,
    output logic [8*VAR_PAIRS-1:0] varTypes,
    // page-table entry bits
    output logic attrIndexBit,
    output logic pageCacheDisable,
    output logic pageWritethrough
);
    // one lookup; defined overlap mixes, bar one probe of the flag
    task present(input [2:0] pg, input fix, input [7:0] ft,
                 input [1:0] hit, input [7:0] t0, input [7:0] t1);
        {attrIndexBit, pageCacheDisable, pageWritethrough} = pg;
        inLowMeg = fix;
        fixedHit = fix;
        fixedType = ft;
        varHit = {{(VAR_PAIRS-2){1'b0}}, hit};
        varTypes = {{(VAR_PAIRS-2){8'h03}}, t1, t0};
    endtask
    // idle: nothing matched, plain page
    initial present(3'h0, 1'h0, 8'h00, 2'h0, 8'h03, 8'h03);
endmodule // mtr_core_pipe

// *** verif/mtr_resolver_test.sv ***
// Purpose: self-checking bench for the resolver
// Assumes: default parameters, one clock
// Notes: lookups are judged a cycle after they are presented
`timescale 1ns/100ps
module mtr_resolver_test;
    localparam logic [63:0] RST_T = 64'h0007_0406_0007_0406;
    localparam logic [63:0] NEW_T = 64'h0001_0405_0607_0006;
    localparam logic [39:0] TYPES = 40'h06_05_04_01_00;
    logic clk = 1'b0, rst = 1'b1, regReq = 1'b0, regWr = 1'b0;
    logic featQuery = 1'b0, globalCacheDisable = 1'b0;
    logic globalNoWriteback = 1'b0;
    logic [11:0] regAddr = 12'h0;
    logic [63:0] regWdata = 64'h0, regRdata_q, varTypes;
    logic [31:0] featWord_q;
    logic [7:0] fixedType, effType, rangeType, varHit;
    logic regAck_q, regFault_q, inLowMeg, fixedHit, attrIndexBit;
    logic pageCacheDisable, pageWritethrough, typeUndef, cacheable;
    logic readAllocShared, writeAlloc, writeToMem, writeHitInval;
    logic combineOk, specReadOk;
    int err_count = 0, n_tests = 0;
    mtr_resolver i_dut (.clk, .rst, .regReq, .regWr, .regAddr, .regWdata,
        .regAck_q, .regRdata_q, .regFault_q, .featQuery, .featWord_q,
        .globalCacheDisable, .globalNoWriteback, .inLowMeg, .fixedHit,
        .fixedType, .varHit, .varTypes, .attrIndexBit, .pageCacheDisable,
        .pageWritethrough, .effType, .rangeType, .typeUndef, .cacheable,
        .readAllocShared, .writeAlloc, .writeToMem, .writeHitInval,
        .combineOk, .specReadOk);
    mtr_core_pipe i_pipe (.inLowMeg, .fixedHit, .fixedType, .varHit,
        .varTypes, .attrIndexBit, .pageCacheDisable, .pageWritethrough);
    // clock
    initial forever #5 clk = ~clk;
    task chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // one access, then an idle cycle so the strobe is never set twice
    task reg_acc(input logic wr, input logic [11:0] a, input logic [63:0] d,
                 input logic ef, input logic [63:0] er);
        regReq = 1'b1;
        regWr = wr;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regReq = 1'b0;
        chk(regAck_q === 1'b1 && regFault_q === ef && regRdata_q === er,
            "register answer");
        @(negedge clk);
    endtask
    task look(input [2:0] pg, input fix, input [7:0] ft, input [1:0] h,
              input [7:0] t0, input [7:0] t1, input [7:0] er,
              input [7:0] ee);
        i_pipe.present(pg, fix, ft, h, t0, t1);
        @(negedge clk);
        chk(rangeType === er && effType === ee && typeUndef === 1'b0,
            "lookup type");
    endtask
    task t_range;
        look(3'h0, 1'h0, 8'h00, 2'h1, 8'h06, 8'h03, 8'h00, 8'h00);
        reg_acc(1'h1, 12'h030, 64'hc00, 1'h0, 64'h0);
        look(3'h0, 1'h0, 8'h00, 2'h3, 8'h06, 8'h06, 8'h06, 8'h06);
        look(3'h0, 1'h0, 8'h00, 2'h3, 8'h00, 8'h06, 8'h00, 8'h00);
        look(3'h0, 1'h0, 8'h00, 2'h3, 8'h04, 8'h06, 8'h04, 8'h04);
        i_pipe.present(3'h0, 1'h0, 8'h00, 2'h3, 8'h01, 8'h06);
        @(negedge clk);
        chk(rangeType === 8'h00 && typeUndef === 1'b1,
            "undefined mix");
        look(3'h0, 1'h1, 8'h05, 2'h1, 8'h06, 8'h03, 8'h05, 8'h05);
        $display("test range done");
    endtask
    task t_page;
        logic [7:0] rt, ex;
        for (int i = 0; i < 5; i++) begin
            rt = TYPES[8*i +: 8];
            for (int p = 0; p < 4; p++) begin
                case (p)
                    0: ex = rt;
                    1: ex = (rt == 8'h06) ? 8'h04 : rt;
                    2: ex = (rt == 8'h01) ? 8'h01 : 8'h00;
                    default: ex = 8'h00;
                endcase
                look(p[2:0], 1'h0, 8'h00, 2'h1, rt, 8'h03, rt,
                     ex);
                if (p == 0 && rt == 8'h01)
                    chk(combineOk === 1'b1 && specReadOk === 1'b1 &&
                        cacheable === 1'b0, "combining flags");
                if (p == 0 && rt == 8'h04)
                    chk(readAllocShared === 1'b1 && writeAlloc === 1'b0 &&
                        writeToMem === 1'b1 && cacheable === 1'b1,
                        "writethrough flags");
                if (p == 0 && rt == 8'h05)
                    chk(writeToMem === 1'b1 && writeAlloc === 1'b0 &&
                        writeHitInval === 1'b1, "protect flags");
            end
        end
        globalCacheDisable = 1'b1;
        look(3'h0, 1'h0, 8'h00, 2'h1, 8'h06, 8'h03, 8'h06, 8'h00);
        globalCacheDisable = 1'b0;
        globalNoWriteback = 1'b1;
        look(3'h0, 1'h0, 8'h00, 2'h1, 8'h06, 8'h03, 8'h06, 8'h00);
        globalNoWriteback = 1'b0;
        $display("test page done");
    endtask
    task t_cap;
        reg_acc(1'h0, 12'h010, 64'h0, 1'h0,
                64'h508);
        reg_acc(1'h1, 12'h010, 64'h0, 1'h1, 64'h0);
        reg_acc(1'h0, 12'h010, 64'h0, 1'h0, 64'h508);
        reg_acc(1'h0, 12'h040, 64'h0, 1'h1, 64'h0);
        featQuery = 1'b1;
        @(negedge clk);
        featQuery = 1'b0;
        chk(featWord_q === 32'h0000_1000, "feature word");
        $display("test capability done");
    endtask
    task t_attr;
        logic [7:0] e;
        reg_acc(1'h0, 12'h020, 64'h0, 1'h0, RST_T);
        reg_acc(1'h1, 12'h020, RST_T | 64'h08, 1'h1, 64'h0);
        reg_acc(1'h1, 12'h020, 64'h02, 1'h1, 64'h0);
        reg_acc(1'h0, 12'h020, 64'h0, 1'h0, RST_T);
        reg_acc(1'h1, 12'h020, NEW_T, 1'h0, 64'h0);
        for (int s = 0; s < 8; s++) begin
            e = NEW_T[8*s +: 8];
            look(s[2:0], 1'h0, 8'h00, 2'h1, 8'h06, 8'h03, 8'h06,
                 (e == 8'h07) ? 8'h00 : e);
        end
        reg_acc(1'h1, 12'h020, RST_T, 1'h0, 64'h0);
        $display("test attribute done");
    endtask
    task close_out;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence after four reset cycles
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_range;
        t_page;
        t_cap;
        t_attr;
        close_out;
    end
    // watchdog, far beyond the sixty or so cycles the tests take
    initial begin
        #20000;
        err_count++;
        close_out;
    end
endmodule // mtr_resolver_test
